//--- core/silde_pkg.sv
package silde_pkg;
  // Clock and blink timing
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned BLINK_HALF_MS   = 250;      // Half period of the common blink
  localparam int unsigned BLINK_HALF_CYC  = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned NUM_CH          = 16;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL    = 12'h000;
  localparam logic [11:0] OFS_MODFLG  = 12'h004;
  localparam logic [11:0] OFS_CHDIAG  = 12'h008;
  localparam logic [11:0] OFS_CHACK   = 12'h00C;
  localparam logic [11:0] OFS_PROC    = 12'h010;
  localparam logic [11:0] OFS_LAMPS   = 12'h014;
  localparam logic [11:0] OFS_IRQST   = 12'h018;
  localparam logic [11:0] OFS_IRQMSK  = 12'h01C;
  localparam logic [11:0] OFS_CHLAMP  = 12'h020;

  // Module flag field positions in the flags register
  localparam int unsigned FLG_BPWR    = 0;  // Backplane supply good
  localparam int unsigned FLG_PARAM   = 1;  // Valid parameters received
  localparam int unsigned FLG_FWUPD   = 2;  // Firmware update running
  localparam int unsigned FLG_HWDEF   = 3;  // Hardware defective
  localparam int unsigned FLG_MODFLT  = 4;  // Module fault
  localparam int unsigned FLG_COMERR  = 5;  // Safety communication error
  localparam int unsigned FLG_MODACK  = 6;  // Module error awaiting acknowledgment
  localparam int unsigned FLG_ADRMIS  = 7;  // Safety address mismatch
  localparam int unsigned FLG_IDENT   = 8;  // Identification for address assignment
  localparam int unsigned FLG_SUPERR  = 9;  // Supply voltage out of range
  localparam int unsigned FLG_LOADPW  = 10; // Load rail voltage present
  localparam int unsigned FLG_W       = 11;

  // Control register fields
  localparam int unsigned CTL_LEGACY  = 0;  // Legacy controller family

  // Interrupt status bits
  localparam int unsigned IRQ_MODE    = 0;  // Module display mode changed
  localparam int unsigned IRQ_CHDIAG  = 1;  // A channel diagnostic rose
  localparam int unsigned IRQ_LOAD    = 2;  // Load rail changed
  localparam int unsigned IRQ_W       = 3;

  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;

  // Module display modes, highest priority first
  typedef enum logic [2:0] {
    SILDE_M_NOPWR = 3'b000,
    SILDE_M_HWDEF = 3'b001,
    SILDE_M_FWUPD = 3'b010,
    SILDE_M_ACK   = 3'b011,
    SILDE_M_DIAG  = 3'b100,
    SILDE_M_START = 3'b101,
    SILDE_M_RUN   = 3'b110
  } silde_mode_e;
endpackage

//--- core/silde_blink.sv
`timescale 1ns/100ps
// Common blink timebase: one phase bit for every flashing lamp
module silde_blink (
  input  wire logic pclk,     // Module clock
  input  wire logic presetn,  // Async reset, active low
  output logic      phase     // Blink phase, toggles each half period
);
  logic [31:0] cnt;
  wire         wrap = (cnt == 32'(silde_pkg::BLINK_HALF_CYC - 1));

  // Free running half-period divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt   <= silde_pkg::RST_ZERO;
      phase <= 1'b0;
    end else begin
      cnt <= wrap ? silde_pkg::RST_ZERO : cnt + 32'h0000_0001;
      if (wrap) begin
        phase <= ~phase;
      end
    end
  end
endmodule // silde_blink

//--- core/silde_top.sv
`timescale 1ns/100ps
// Operation
// - No backplane power: operate, fault lamps dark
// - Startup: operate blinks, fault dark
// - Parameterized, no fault: operate steady
// - Firmware update: operate dark, fault blinks
// - Diagnostic event: operate on (dark for address mismatch or identification without parameters), fault blinks
// - Acknowledgment pending: lamps flash alternately
// - Supply lamp follows load rail
// - Healthy channel: status follows signal
// - Diagnosed channel: signal zero, diagnostics on
// - Channel awaiting acknowledgment: lamps alternate
// - Legacy: healthy channel may await acknowledgment
// - Address mismatch: status dark, diagnostics on
// - Identification: status blinks, diagnostics dark
// - Supply error: diagnostics on, fault blinks
module silde_top (
  input  wire logic        pclk,         // Module clock, 100 MHz
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic [31:0] paddr,        // APB address
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  output logic             run_lamp,     // Operate lamp
  output logic             err_lamp,     // Fault lamp
  output logic             supply_lamp,  // Load rail lamp
  output logic      [15:0] chan_status,  // Per channel status lamps
  output logic      [15:0] chan_diag,    // Per channel diagnostics lamps
  output logic      [15:0] proc_signal,  // Reported process signals
  output logic             irq           // Level interrupt
);
  localparam int unsigned N = silde_pkg::NUM_CH;

  // Software-written state
  logic [31:0]                  ctrl;
  logic [silde_pkg::FLG_W-1:0]  flags;
  logic [N-1:0]                 ch_diag_in;
  logic [N-1:0]                 ch_ack_in;
  logic [N-1:0]                 proc_in;
  logic [silde_pkg::IRQ_W-1:0]  irq_st;
  logic [silde_pkg::IRQ_W-1:0]  irq_msk;

  // Blink phase from the common divider
  logic phase;

  silde_blink u_blink (
    .pclk    (pclk),
    .presetn (presetn),
    .phase   (phase)
  );

  // APB decode; zero wait states so pready is tied high
  wire wr_en  = psel & penable & pwrite;
  wire [11:0] ofs = paddr[11:0];
  wire hit_ctrl  = (ofs == silde_pkg::OFS_CTRL);
  wire hit_flg   = (ofs == silde_pkg::OFS_MODFLG);
  wire hit_cdg   = (ofs == silde_pkg::OFS_CHDIAG);
  wire hit_cak   = (ofs == silde_pkg::OFS_CHACK);
  wire hit_proc  = (ofs == silde_pkg::OFS_PROC);
  wire hit_lamps = (ofs == silde_pkg::OFS_LAMPS);
  wire hit_ist   = (ofs == silde_pkg::OFS_IRQST);
  wire hit_imsk  = (ofs == silde_pkg::OFS_IRQMSK);
  wire hit_chl   = (ofs == silde_pkg::OFS_CHLAMP);
  wire hit_any   = hit_ctrl | hit_flg | hit_cdg | hit_cak | hit_proc | hit_lamps | hit_ist | hit_imsk | hit_chl;
  wire bad_addr  = (paddr[31:12] != 20'h00000) | (paddr[1:0] != 2'h0) | ~hit_any;

  // Module conditions
  wire legacy    = ctrl[silde_pkg::CTL_LEGACY];
  wire bpwr      = flags[silde_pkg::FLG_BPWR];
  wire any_diag  = |ch_diag_in;
  wire any_ack   = |ch_ack_in;
  wire adr_mis   = flags[silde_pkg::FLG_ADRMIS];
  wire ident     = flags[silde_pkg::FLG_IDENT];
  wire sup_err   = flags[silde_pkg::FLG_SUPERR];
  // Acknowledgment pending: module error in newer family, any channel in legacy
  wire ack_pend  = legacy ? any_ack : flags[silde_pkg::FLG_MODACK];
  // Newer family counts waiting channels as diagnostic events
  wire diag_evt  = flags[silde_pkg::FLG_MODFLT] | flags[silde_pkg::FLG_COMERR] | any_diag | sup_err
                   | adr_mis | ident | (~legacy & any_ack);

  // Priority encode of the module display mode
  silde_pkg::silde_mode_e mode;
  always_comb begin
    if (!bpwr) begin
      mode = silde_pkg::SILDE_M_NOPWR;
    end else if (flags[silde_pkg::FLG_HWDEF]) begin
      mode = silde_pkg::SILDE_M_HWDEF;
    end else if (flags[silde_pkg::FLG_FWUPD]) begin
      mode = silde_pkg::SILDE_M_FWUPD;
    end else if (ack_pend) begin
      mode = silde_pkg::SILDE_M_ACK;
    end else if (diag_evt) begin
      mode = silde_pkg::SILDE_M_DIAG;
    end else if (!flags[silde_pkg::FLG_PARAM]) begin
      mode = silde_pkg::SILDE_M_START;
    end else begin
      mode = silde_pkg::SILDE_M_RUN;
    end
  end

  // Lamp pattern per mode, all blinking from the one phase
  logic next_run;
  logic next_err;
  always_comb begin
    next_run = 1'b0;
    next_err = 1'b0;
    unique case (mode)
      silde_pkg::SILDE_M_NOPWR: begin
        next_run = 1'b0;
        next_err = 1'b0;
      end
      silde_pkg::SILDE_M_HWDEF: begin
        next_run = phase;
        next_err = phase;
      end
      silde_pkg::SILDE_M_FWUPD: begin
        next_run = 1'b0;
        next_err = phase;
      end
      silde_pkg::SILDE_M_ACK: begin
        next_run = phase;
        next_err = ~phase;
      end
      silde_pkg::SILDE_M_DIAG: begin
        next_run = ~(adr_mis | ident) | flags[silde_pkg::FLG_PARAM];
        next_err = phase;
      end
      silde_pkg::SILDE_M_START: begin
        next_run = phase;
        next_err = 1'b0;
      end
      silde_pkg::SILDE_M_RUN: begin
        next_run = 1'b1;
        next_err = 1'b0;
      end
      default: begin
        next_run = 1'b0;
        next_err = 1'b0;
      end
    endcase
  end

  // Per channel lamp selection
  logic [N-1:0] next_stat;
  logic [N-1:0] next_diag;
  logic [N-1:0] next_proc;
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (adr_mis) begin
        next_stat[i] = 1'b0;
        next_diag[i] = 1'b1;
        next_proc[i] = 1'b0;
      end else if (ident) begin
        next_stat[i] = phase;
        next_diag[i] = 1'b0;
        next_proc[i] = 1'b0;
      end else if (sup_err) begin
        next_stat[i] = 1'b0;
        next_diag[i] = 1'b1;
        next_proc[i] = 1'b0;
      end else if (ch_ack_in[i]) begin
        next_stat[i] = phase;
        next_diag[i] = ~phase;
        next_proc[i] = 1'b0;
      end else if (ch_diag_in[i]) begin
        next_stat[i] = 1'b0;
        next_diag[i] = 1'b1;
        next_proc[i] = 1'b0;
      end else begin
        next_stat[i] = proc_in[i];
        next_diag[i] = 1'b0;
        next_proc[i] = proc_in[i];
      end
    end
  end

  // Events for the interrupt status
  logic [2:0]   mode_q;
  logic [N-1:0] diag_q;
  logic         load_q;
  wire  load_pw = flags[silde_pkg::FLG_LOADPW];
  wire [silde_pkg::IRQ_W-1:0] evt = {load_pw ^ load_q, |(ch_diag_in & ~diag_q), mode != mode_q};

  // Registered lamp outputs, one cycle behind the inputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_lamp    <= 1'b0;
      err_lamp    <= 1'b0;
      supply_lamp <= 1'b0;
      chan_status <= 16'h0000;
      chan_diag   <= 16'h0000;
      proc_signal <= 16'h0000;
      mode_q      <= 3'h0;
      diag_q      <= 16'h0000;
      load_q      <= 1'b0;
    end else begin
      run_lamp    <= next_run;
      err_lamp    <= next_err;
      supply_lamp <= load_pw;
      chan_status <= next_stat;
      chan_diag   <= next_diag;
      proc_signal <= next_proc;
      mode_q      <= mode;
      diag_q      <= ch_diag_in;
      load_q      <= load_pw;
    end
  end

  // Register writes; a new event wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl       <= silde_pkg::RST_ZERO;
      flags      <= '0;
      ch_diag_in <= 16'h0000;
      ch_ack_in  <= 16'h0000;
      proc_in    <= 16'h0000;
      irq_st     <= '0;
      irq_msk    <= '0;
    end else begin
      if (wr_en && hit_ctrl) ctrl <= pwdata;
      if (wr_en && hit_flg) flags <= pwdata[silde_pkg::FLG_W-1:0];
      if (wr_en && hit_cdg) ch_diag_in <= pwdata[N-1:0];
      if (wr_en && hit_cak) ch_ack_in <= pwdata[N-1:0];
      if (wr_en && hit_proc) proc_in <= pwdata[N-1:0];
      if (wr_en && hit_imsk) irq_msk <= pwdata[silde_pkg::IRQ_W-1:0];
      irq_st <= (irq_st & ~((wr_en && hit_ist) ? pwdata[silde_pkg::IRQ_W-1:0] : '0)) | evt;
    end
  end

  assign irq = |(irq_st & irq_msk);

  // Read mux; lamp register shows the block's own state
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = silde_pkg::RST_ZERO;
    if (hit_ctrl)  rd_mux = ctrl;
    if (hit_flg)   rd_mux = 32'(flags);
    if (hit_cdg)   rd_mux = 32'(ch_diag_in);
    if (hit_cak)   rd_mux = 32'(ch_ack_in);
    if (hit_proc)  rd_mux = 32'(proc_in);
    if (hit_lamps) rd_mux = {24'h000000, 2'h0, mode_q, supply_lamp, err_lamp, run_lamp};
    if (hit_ist)   rd_mux = 32'(irq_st);
    if (hit_imsk)  rd_mux = 32'(irq_msk);
    if (hit_chl)   rd_mux = {chan_diag, chan_status};
  end

  // Read data is captured in the setup cycle, so it is valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= silde_pkg::RST_ZERO;
    end else if (psel && !penable && !pwrite) begin
      prdata <= bad_addr ? silde_pkg::RST_ZERO : rd_mux;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & bad_addr;

  // Assertions
  property p_nopwr;
    @(posedge pclk) disable iff (!presetn)
      !bpwr |=> (!run_lamp && !err_lamp);
  endproperty
  a_nopwr: assert property (p_nopwr) else $error("Lamps lit without backplane power");

  property p_run;
    @(posedge pclk) disable iff (!presetn)
      (mode == silde_pkg::SILDE_M_RUN) |=> (run_lamp && !err_lamp);
  endproperty
  a_run: assert property (p_run) else $error("Running pattern wrong");

  property p_fw;
    @(posedge pclk) disable iff (!presetn)
      (mode == silde_pkg::SILDE_M_FWUPD) |=> (!run_lamp && err_lamp == $past(phase));
  endproperty
  a_fw: assert property (p_fw) else $error("Firmware update pattern wrong");

  property p_ack;
    @(posedge pclk) disable iff (!presetn)
      (mode == silde_pkg::SILDE_M_ACK) |=> (run_lamp != err_lamp);
  endproperty
  a_ack: assert property (p_ack) else $error("Acknowledge lamps not alternating");

  property p_hw;
    @(posedge pclk) disable iff (!presetn)
      (bpwr && flags[silde_pkg::FLG_HWDEF]) |=> (run_lamp == err_lamp);
  endproperty
  a_hw: assert property (p_hw) else $error("Defect lamps not in phase");

  property p_supply;
    @(posedge pclk) disable iff (!presetn)
      $changed(load_pw) |=> (supply_lamp == $past(load_pw));
  endproperty
  a_supply: assert property (p_supply) else $error("Supply lamp not following rail");

  property p_chdiag;
    @(posedge pclk) disable iff (!presetn)
      (ch_diag_in[0] && !ch_ack_in[0] && !ident) |=> (!chan_status[0] && chan_diag[0] && !proc_signal[0]);
  endproperty
  a_chdiag: assert property (p_chdiag) else $error("Diagnosed channel display wrong");

  property p_mis;
    @(posedge pclk) disable iff (!presetn)
      adr_mis |=> (chan_status == 16'h0000 && chan_diag == 16'hFFFF);
  endproperty
  a_mis: assert property (p_mis) else $error("Address mismatch display wrong");

  property p_chack;
    @(posedge pclk) disable iff (!presetn)
      (ch_ack_in[0] && !adr_mis && !ident && !sup_err) |=> (chan_status[0] != chan_diag[0]);
  endproperty
  a_chack: assert property (p_chack) else $error("Channel acknowledge not alternating");

  property p_start;
    @(posedge pclk) disable iff (!presetn)
      (mode == silde_pkg::SILDE_M_START) |=> !err_lamp;
  endproperty
  a_start: assert property (p_start) else $error("Fault lamp lit during startup");

  property p_alt;
    @(posedge pclk) disable iff (!presetn)
      (mode == silde_pkg::SILDE_M_ACK) |=> (run_lamp == $past(phase) && err_lamp == !$past(phase));
  endproperty
  a_alt: assert property (p_alt) else $error("Alternating lamps not tied to blink phase");

  property p_diag;
    @(posedge pclk) disable iff (!presetn)
      (mode == silde_pkg::SILDE_M_DIAG && flags[silde_pkg::FLG_PARAM]) |=> (run_lamp && err_lamp == $past(phase));
  endproperty
  a_diag: assert property (p_diag) else $error("Diagnostic event pattern wrong");

  property p_chnorm;
    @(posedge pclk) disable iff (!presetn)
      (!ch_diag_in[0] && !ch_ack_in[0] && !adr_mis && !ident && !sup_err) |=>
        (chan_status[0] == $past(proc_in[0]) && !chan_diag[0] && proc_signal[0] == $past(proc_in[0]));
  endproperty
  a_chnorm: assert property (p_chnorm) else $error("Healthy channel display wrong");

  property p_ident;
    @(posedge pclk) disable iff (!presetn)
      (ident && !adr_mis) |=> (chan_diag == 16'h0000 && chan_status == {16{$past(phase)}});
  endproperty
  a_ident: assert property (p_ident) else $error("Identification display wrong");
endmodule // silde_top

//--- dv/silde_panel.sv
`timescale 1ns/100ps
// Front panel as the operator sees it: lamps latched once per clock
module silde_panel (
  input  wire logic        pclk,         // Module clock
  input  wire logic        presetn,      // Async reset, active low
  input  wire logic        run_lamp,     // Operate lamp
  input  wire logic        err_lamp,     // Fault lamp
  input  wire logic        supply_lamp,  // Load rail lamp
  input  wire logic [15:0] chan_status,  // Channel status lamps
  input  wire logic [15:0] chan_diag,    // Channel diagnostics lamps
  output logic      [34:0] view,         // What the operator reads
  output logic      [15:0] run_flashes   // Operate lamp changes seen
);
  // One sample a cycle; an eye cannot resolve anything finer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      view        <= 35'h0;
      run_flashes <= 16'h0;
    end else begin
      view <= {chan_diag, chan_status, supply_lamp, err_lamp, run_lamp};
      if (run_lamp != view[0]) begin
        run_flashes <= run_flashes + 16'h1;
      end
    end
  end
endmodule // silde_panel

//--- dv/safety_input_status_led_encoder_bench.sv
`timescale 1ns/100ps
module safety_input_status_led_encoder_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, run_lamp, err_lamp, supply_lamp, irq;
  logic [15:0] chan_status, chan_diag, proc_signal, run_flashes;
  logic [34:0] view;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  localparam logic [31:0] BP = 32'h1 << silde_pkg::FLG_BPWR;
  localparam logic [31:0] PA = 32'h1 << silde_pkg::FLG_PARAM;
  localparam logic [31:0] FW = 32'h1 << silde_pkg::FLG_FWUPD;
  localparam logic [31:0] HW = 32'h1 << silde_pkg::FLG_HWDEF;
  localparam logic [31:0] MF = 32'h1 << silde_pkg::FLG_MODFLT;
  localparam logic [31:0] CE = 32'h1 << silde_pkg::FLG_COMERR;
  localparam logic [31:0] MA = 32'h1 << silde_pkg::FLG_MODACK;
  localparam logic [31:0] AM = 32'h1 << silde_pkg::FLG_ADRMIS;
  localparam logic [31:0] ID = 32'h1 << silde_pkg::FLG_IDENT;
  localparam logic [31:0] SE = 32'h1 << silde_pkg::FLG_SUPERR;
  localparam logic [31:0] LD = 32'h1 << silde_pkg::FLG_LOADPW;

  always #5 pclk = ~pclk;

  silde_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_lamp(run_lamp), .err_lamp(err_lamp), .supply_lamp(supply_lamp), .chan_status(chan_status),
    .chan_diag(chan_diag), .proc_signal(proc_signal), .irq(irq));

  silde_panel panel (.pclk(pclk), .presetn(presetn), .run_lamp(run_lamp), .err_lamp(err_lamp),
    .supply_lamp(supply_lamp), .chan_status(chan_status), .chan_diag(chan_diag), .view(view),
    .run_flashes(run_flashes));

  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; the ceiling leaves ample room
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high, only the bench timeout ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {20'h0, a};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk({2'b0, e, r}, {2'b0, exp_err, exp});
  endtask

  // Lamps follow a write one cycle later; two edges leave margin
  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  // Module lamps and displayed mode for one set of flags
  task automatic mode_case(input logic [31:0] f, input silde_pkg::silde_mode_e m, input logic run,
                           input logic err);
    wr(silde_pkg::OFS_MODFLG, f);
    settle();
    rd(silde_pkg::OFS_LAMPS, {26'h0, m, 1'b0, err, run}, 1'b0);
    chk({33'h0, view[1:0]}, {33'h0, err, run});
  endtask

  // Channel lamps seen on the panel and through the read-back register
  task automatic ch_case(input logic [15:0] st, input logic [15:0] dg);
    settle();
    chk({3'h0, view[34:3]}, {3'h0, dg, st});
    rd(silde_pkg::OFS_CHLAMP, {dg, st}, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Blink phase stays 0 for the whole run: a lamp flashing with the phase shows dark, one flashing against it shows lit
    rd(silde_pkg::OFS_CTRL, silde_pkg::RST_ZERO, 1'b0);
    rd(silde_pkg::OFS_IRQMSK, silde_pkg::RST_ZERO, 1'b0);
    rd(12'h024, 32'h0, 1'b1);
    mode_case(32'h0, silde_pkg::SILDE_M_NOPWR, 1'b0, 1'b0);
    mode_case(HW | FW, silde_pkg::SILDE_M_NOPWR, 1'b0, 1'b0);
    mode_case(BP, silde_pkg::SILDE_M_START, 1'b0, 1'b0);
    mode_case(BP | PA, silde_pkg::SILDE_M_RUN, 1'b1, 1'b0);
    mode_case(BP | PA | FW | MF, silde_pkg::SILDE_M_FWUPD, 1'b0, 1'b0);
    mode_case(BP | PA | MF, silde_pkg::SILDE_M_DIAG, 1'b1, 1'b0);
    mode_case(BP | PA | CE, silde_pkg::SILDE_M_DIAG, 1'b1, 1'b0);
    mode_case(BP | PA | MA | MF, silde_pkg::SILDE_M_ACK, 1'b0, 1'b1);
    mode_case(BP | PA | HW | FW | MA, silde_pkg::SILDE_M_HWDEF, 1'b0, 1'b0);
    mode_case(BP | PA, silde_pkg::SILDE_M_RUN, 1'b1, 1'b0);
    wr(silde_pkg::OFS_PROC, 32'h0000A5C3);
    ch_case(16'hA5C3, 16'h0000);
    chk({19'h0, proc_signal}, {19'h0, 16'hA5C3});
    wr(silde_pkg::OFS_CHDIAG, 32'h000000FF);
    ch_case(16'hA500, 16'h00FF);
    chk({19'h0, proc_signal}, {19'h0, 16'hA500});
    chk({34'h0, run_lamp}, 35'h1);
    wr(silde_pkg::OFS_CHDIAG, 32'h0);
    wr(silde_pkg::OFS_CHACK, 32'h00000100);
    ch_case(16'hA4C3, 16'h0100);
    rd(silde_pkg::OFS_LAMPS, {26'h0, silde_pkg::SILDE_M_DIAG, 3'b001}, 1'b0);
    wr(silde_pkg::OFS_CTRL, 32'h1);
    ch_case(16'hA4C3, 16'h0100);
    rd(silde_pkg::OFS_LAMPS, {26'h0, silde_pkg::SILDE_M_ACK, 3'b010}, 1'b0);
    wr(silde_pkg::OFS_CTRL, 32'h0);
    wr(silde_pkg::OFS_CHACK, 32'h0);
    wr(silde_pkg::OFS_MODFLG, BP | PA | AM);
    ch_case(16'h0000, 16'hFFFF);
    wr(silde_pkg::OFS_MODFLG, BP | PA | ID);
    ch_case(16'h0000, 16'h0000);
    wr(silde_pkg::OFS_MODFLG, BP | PA | SE);
    ch_case(16'h0000, 16'hFFFF);
    chk({34'h0, run_lamp}, 35'h1);
    // Interrupts: clear, raise, mask, clear again
    wr(silde_pkg::OFS_MODFLG, 32'h0);
    wr(silde_pkg::OFS_IRQST, 32'h7);
    settle();
    chk({34'h0, irq}, 35'h0);
    wr(silde_pkg::OFS_MODFLG, BP | PA | LD);
    settle();
    chk({34'h0, supply_lamp}, 35'h1);
    rd(silde_pkg::OFS_IRQST, 32'h5, 1'b0);
    chk({34'h0, irq}, 35'h0);
    wr(silde_pkg::OFS_IRQMSK, 32'h1);
    settle();
    chk({34'h0, irq}, 35'h1);
    wr(silde_pkg::OFS_IRQST, 32'h1);
    settle();
    chk({34'h0, irq}, 35'h0);
    rd(silde_pkg::OFS_IRQST, 32'h4, 1'b0);
    wr(silde_pkg::OFS_IRQMSK, 32'h2);
    wr(silde_pkg::OFS_CHDIAG, 32'h1);
    settle();
    chk({34'h0, irq}, 35'h1);
    rd(silde_pkg::OFS_IRQST, 32'h7, 1'b0);
    wr(silde_pkg::OFS_MODFLG, BP | PA);
    settle();
    chk({34'h0, supply_lamp}, 35'h0);
    // Operate lamp changed nine times across all the mode, channel and interrupt steps above
    chk({19'h0, run_flashes}, 35'h9);
    tally_and_finish();
  end
endmodule // safety_input_status_led_encoder_bench
